/* File: core/scpc_control.sv */
// Register file and control logic of the spread clock and PLL control block.
// Notes on behaviour
// - Writing 1 to the load bit reloads the modulator; the bit self-clears.
// - Spread enable rising 0 to 1 performs the same reload as the load bit.
// - FIFO reset at spread start; with its bit set, also at each line sync.
// - Wave reset bit set: line sync resets the waveform; clear: no effect.
// - Second PLL override forces its lock to 1; advised while spreading.
// - First PLL override forces its lock indication to 1.
// - Mode 11 all no mult; 10 all off (default); 01 all mult; 00 output mult.
// - Multiplier M equals stored numerator plus one, 1 to 256.
// - Divider N equals stored denominator plus one, 1 to 256.
// - Multiplying PLL output is input frequency times M divided by N.
// - With sync start set, spreading begins at the next line sync.
`timescale 1ns/100ps
`default_nettype none
module scpc_control
  import scpc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic line_sync_pulse,
  input wire logic first_pll_lock_raw,
  input wire logic second_pll_lock_raw,
  output logic modulator_load,
  output logic spreading,
  output logic fifo_reset,
  output logic wave_reset,
  output logic max_modulation_rate,
  output logic first_pll_lock,
  output logic second_pll_lock,
  output logic pll_enable,
  output logic spread_all_clocks,
  output logic mult_enable,
  output logic [8:0] pll_mult_m,
  output logic [8:0] pll_div_n
);

  logic [1:0] ctl1_q;
  logic [6:0] ctl2_q;
  logic [7:0] num_q;
  logic [7:0] den_q;
  logic load_q;
  logic [7:0] rdata_q;
  logic ls_s1_q, ls_s2_q, ls_s3_q;
  logic l1_s1_q, l1_s2_q;
  logic l2_s1_q, l2_s2_q;
  scpc_state_e state_q, state_d;
  logic fifo_rst_q, wave_rst_q, maxr_q, lock1_q, lock2_q;
  logic pll_en_q, all_q, mult_q;
  logic spread_q;
  logic [8:0] m_q, n_q;

  // Address decode and field extraction
  wire wr_ctl1 = reg_wr && reg_addr == SCPC_OFS_SPREAD_CONTROL_FIRST;
  wire wr_ctl2 = reg_wr && reg_addr == SCPC_OFS_SPREAD_CONTROL_SECOND;
  wire wr_num = reg_wr && reg_addr == SCPC_OFS_PLL_MULTIPLIER_NUMERATOR;
  wire wr_den = reg_wr && reg_addr == SCPC_OFS_PLL_DIVIDER_DENOMINATOR;
  wire en = ctl1_q[SCPC_BIT_SPREAD_ENABLE];
  wire sync_start = ctl1_q[SCPC_BIT_LINE_SYNC_START];
  wire fifo_at_sync = ctl2_q[SCPC_BIT_FIFO_RESET_AT_SYNC];
  wire wave_at_sync = ctl2_q[SCPC_BIT_WAVE_RESET_AT_SYNC];
  wire ovr2 = ctl2_q[SCPC_BIT_SECOND_PLL_OVERRIDE];
  wire ovr1 = ctl2_q[SCPC_BIT_FIRST_PLL_OVERRIDE];
  wire max_rate = ctl2_q[SCPC_BIT_MAX_MODULATION_RATE];
  wire [1:0] mode = ctl2_q[SCPC_BIT_MODE_HI:SCPC_BIT_MODE_LO];
  wire mode_off = mode == SCPC_MODE_DISABLED;

  // Load request: explicit bit or enable going 0 to 1
  wire load_bit_wr = wr_ctl2 && reg_wdata[SCPC_BIT_LOAD_MODULATOR];
  wire en_rise = wr_ctl1 && reg_wdata[SCPC_BIT_SPREAD_ENABLE] && !en;
  wire load_req = load_bit_wr || en_rise;
  // A load only takes effect if enable is set and the mode is not disabled after this cycle
  wire en_next = wr_ctl1 ? reg_wdata[SCPC_BIT_SPREAD_ENABLE] : en;
  wire sync_next = wr_ctl1 ? reg_wdata[SCPC_BIT_LINE_SYNC_START] : sync_start;
  wire [1:0] mode_next = wr_ctl2 ? reg_wdata[1:0] : mode;
  wire run_ok = en_next && mode_next != SCPC_MODE_DISABLED;

  wire ls_pulse = ls_s2_q && !ls_s3_q;
  wire start_evt = (state_d == SCPC_ST_SPREAD) && (state_q != SCPC_ST_SPREAD
    || load_req);

  // Modulator sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      SCPC_ST_IDLE: begin
        if (load_req && run_ok) begin
          state_d = sync_next ? SCPC_ST_WAIT_SYNC : SCPC_ST_SPREAD;
        end
      end
      SCPC_ST_WAIT_SYNC: begin
        if (!run_ok) begin
          state_d = SCPC_ST_IDLE;
        end else if (load_req) begin
          state_d = sync_next ? SCPC_ST_WAIT_SYNC : SCPC_ST_SPREAD;
        end else if (ls_pulse) begin
          state_d = SCPC_ST_SPREAD;
        end
      end
      SCPC_ST_SPREAD: begin
        if (!run_ok) begin
          state_d = SCPC_ST_IDLE;
        end else if (load_req && sync_next) begin
          state_d = SCPC_ST_WAIT_SYNC;
        end
      end
      default: begin
        state_d = SCPC_ST_IDLE;
      end
    endcase
  end

  // Read mux; unmapped addresses return zero
  wire [7:0] stat = {4'h0, lock2_q, lock1_q,
    state_q == SCPC_ST_WAIT_SYNC, state_q == SCPC_ST_SPREAD};
  wire [7:0] rd_mux =
    reg_addr == SCPC_OFS_SPREAD_CONTROL_FIRST ? {6'h00, ctl1_q} :
    reg_addr == SCPC_OFS_SPREAD_CONTROL_SECOND ? {1'b0, ctl2_q} :
    reg_addr == SCPC_OFS_PLL_MULTIPLIER_NUMERATOR ? num_q :
    reg_addr == SCPC_OFS_PLL_DIVIDER_DENOMINATOR ? den_q :
    reg_addr == SCPC_OFS_SPREAD_STATUS ? stat : 8'h00;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl1_q <= SCPC_RST_SPREAD_CONTROL_FIRST;
      ctl2_q <= SCPC_RST_SPREAD_CONTROL_SECOND;
      num_q <= SCPC_RST_PLL_MULTIPLIER_NUMERATOR;
      den_q <= SCPC_RST_PLL_DIVIDER_DENOMINATOR;
      rdata_q <= 8'h00;
    end else begin
      if (wr_ctl1) begin
        ctl1_q <= reg_wdata[1:0];
      end
      if (wr_ctl2) begin
        ctl2_q <= reg_wdata[6:0];
      end
      if (wr_num) begin
        num_q <= reg_wdata;
      end
      if (wr_den) begin
        den_q <= reg_wdata;
      end
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Pins from outside pass two flops before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ls_s1_q <= 1'b0;
      ls_s2_q <= 1'b0;
      ls_s3_q <= 1'b0;
      l1_s1_q <= 1'b0;
      l1_s2_q <= 1'b0;
      l2_s1_q <= 1'b0;
      l2_s2_q <= 1'b0;
    end else begin
      ls_s1_q <= line_sync_pulse;
      ls_s2_q <= ls_s1_q;
      ls_s3_q <= ls_s2_q;
      l1_s1_q <= first_pll_lock_raw;
      l1_s2_q <= l1_s1_q;
      l2_s1_q <= second_pll_lock_raw;
      l2_s2_q <= l2_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SCPC_ST_IDLE;
      spread_q <= 1'b0;
      load_q <= 1'b0;
      fifo_rst_q <= 1'b0;
      wave_rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Registered copy so the pin comes straight from a flop
      spread_q <= state_d == SCPC_ST_SPREAD;
      load_q <= load_req;
      fifo_rst_q <= start_evt || (fifo_at_sync && ls_pulse);
      wave_rst_q <= wave_at_sync && ls_pulse;
    end
  end

  // Lock indications, mode decode and ratio outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      maxr_q <= 1'b0;
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
      pll_en_q <= 1'b0;
      all_q <= 1'b0;
      mult_q <= 1'b0;
      m_q <= SCPC_RATIO_OFFSET;
      n_q <= SCPC_RATIO_OFFSET;
    end else begin
      maxr_q <= max_rate;
      lock1_q <= l1_s2_q || ovr1;
      lock2_q <= l2_s2_q || ovr2;
      pll_en_q <= !mode_off;
      all_q <= !mode_off && mode[0];
      mult_q <= !mode[1];
      m_q <= {1'b0, num_q} + SCPC_RATIO_OFFSET;
      n_q <= {1'b0, den_q} + SCPC_RATIO_OFFSET;
    end
  end

  assign reg_rdata = rdata_q;
  assign modulator_load = load_q;
  assign spreading = spread_q;
  assign fifo_reset = fifo_rst_q;
  assign wave_reset = wave_rst_q;
  assign max_modulation_rate = maxr_q;
  assign first_pll_lock = lock1_q;
  assign second_pll_lock = lock2_q;
  assign pll_enable = pll_en_q;
  assign spread_all_clocks = all_q;
  assign mult_enable = mult_q;
  assign pll_mult_m = m_q;
  assign pll_div_n = n_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_load_bit_pulse: assert property (
    load_bit_wr |=> modulator_load)
    else $error("load bit write gave no reload pulse");

  chk_load_self_clear: assert property (
    load_bit_wr ##1 !reg_wr |=> !modulator_load
      && reg_rdata[SCPC_BIT_LOAD_MODULATOR] == 1'b0)
    else $error("load bit did not clear itself");

  chk_enable_rise_load: assert property (
    wr_ctl1 && reg_wdata[0] && !en |=> modulator_load && en)
    else $error("enable rise gave no reload");

  chk_fifo_at_sync: assert property (
    ls_pulse && fifo_at_sync |=> fifo_reset)
    else $error("fifo not reset at line sync");

  chk_fifo_only_start: assert property (
    !fifo_at_sync && !start_evt |=> !fifo_reset)
    else $error("fifo reset without spread start");

  chk_wave_sync: assert property (
    ls_pulse |=> wave_reset == $past(wave_at_sync))
    else $error("waveform reset disagrees with its bit");

  chk_second_lock: assert property (
    ovr2 |=> second_pll_lock)
    else $error("second pll lock not forced");

  chk_first_lock: assert property (
    ovr1 |=> first_pll_lock)
    else $error("first pll lock not forced");

  chk_max_rate: assert property (
    $changed(max_rate) |=> max_modulation_rate == $past(max_rate))
    else $error("max rate output lags its bit");

  chk_mode_off: assert property (
    mode_off ##1 mode_off |-> !pll_enable && !spreading)
    else $error("disabled mode still runs pll or spread");

  chk_ratio_m: assert property (
    ##1 pll_mult_m == {1'b0, $past(num_q)} + 9'h001)
    else $error("multiplier is not numerator plus one");

  chk_ratio_n: assert property (
    ##1 pll_div_n == {1'b0, $past(den_q)} + 9'h001)
    else $error("divider is not denominator plus one");

  chk_wait_sync: assert property (
    state_q == SCPC_ST_WAIT_SYNC && !ls_pulse && !load_req |=> !spreading)
    else $error("spreading began before line sync");

endmodule
`default_nettype wire

/* File: include/scpc_pkg.sv */
// Package of offsets, field positions, reset values and codes for scpc.
package scpc_pkg;
  // Register offsets
  localparam logic [7:0] SCPC_OFS_SPREAD_CONTROL_FIRST = 8'h1a;
  localparam logic [7:0] SCPC_OFS_SPREAD_CONTROL_SECOND = 8'h1b;
  localparam logic [7:0] SCPC_OFS_PLL_MULTIPLIER_NUMERATOR = 8'h1c;
  localparam logic [7:0] SCPC_OFS_PLL_DIVIDER_DENOMINATOR = 8'h1d;
  localparam logic [7:0] SCPC_OFS_SPREAD_STATUS = 8'h1f;

  // Fields of spread_control_first
  localparam int SCPC_BIT_SPREAD_ENABLE = 0;
  localparam int SCPC_BIT_LINE_SYNC_START = 1;

  // Fields of spread_control_second
  localparam int SCPC_BIT_LOAD_MODULATOR = 7;
  localparam int SCPC_BIT_FIFO_RESET_AT_SYNC = 6;
  localparam int SCPC_BIT_WAVE_RESET_AT_SYNC = 5;
  localparam int SCPC_BIT_SECOND_PLL_OVERRIDE = 4;
  localparam int SCPC_BIT_FIRST_PLL_OVERRIDE = 3;
  localparam int SCPC_BIT_MAX_MODULATION_RATE = 2;
  localparam int SCPC_BIT_MODE_HI = 1;
  localparam int SCPC_BIT_MODE_LO = 0;

  // Fields of spread_status
  localparam int SCPC_BIT_STAT_SPREADING = 0;
  localparam int SCPC_BIT_STAT_WAITING = 1;
  localparam int SCPC_BIT_STAT_FIRST_LOCK = 2;
  localparam int SCPC_BIT_STAT_SECOND_LOCK = 3;

  // Reset values
  localparam logic [1:0] SCPC_RST_SPREAD_CONTROL_FIRST = 2'h0;
  localparam logic [6:0] SCPC_RST_SPREAD_CONTROL_SECOND = 7'h02;
  localparam logic [7:0] SCPC_RST_PLL_MULTIPLIER_NUMERATOR = 8'h00;
  localparam logic [7:0] SCPC_RST_PLL_DIVIDER_DENOMINATOR = 8'h00;

  // PLL mode codes
  localparam logic [1:0] SCPC_MODE_OUT_ONLY_MULT = 2'h0;
  localparam logic [1:0] SCPC_MODE_ALL_MULT = 2'h1;
  localparam logic [1:0] SCPC_MODE_DISABLED = 2'h2;
  localparam logic [1:0] SCPC_MODE_ALL_NO_MULT = 2'h3;

  // Offset added to a stored ratio value
  localparam logic [8:0] SCPC_RATIO_OFFSET = 9'h001;

  typedef enum logic [1:0] {
    SCPC_ST_IDLE,
    SCPC_ST_WAIT_SYNC,
    SCPC_ST_SPREAD
  } scpc_state_e;
endpackage

/* File: tb/scpc_control_bench.sv */
// Self-checking bench for the spread clock and PLL control block.
`timescale 1ns/100ps
`default_nettype none
module scpc_control_bench;
  import scpc_pkg::*;
  logic mclk, arst_n, reg_wr, reg_rd, line_sync_pulse;
  logic first_pll_lock_raw, second_pll_lock_raw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, nv, dv;
  logic modulator_load, spreading, fifo_reset, wave_reset;
  logic max_modulation_rate, first_pll_lock, second_pll_lock;
  logic pll_enable, spread_all_clocks, mult_enable;
  logic [8:0] pll_mult_m, pll_div_n;
  logic [2:0] raw;
  int n_mismatch = 0;
  int n_tests = 0;
  int mdl[int];

  scpc_control dut_u (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .line_sync_pulse, .first_pll_lock_raw,
    .second_pll_lock_raw, .modulator_load, .spreading, .fifo_reset,
    .wave_reset, .max_modulation_rate, .first_pll_lock, .second_pll_lock,
    .pll_enable, .spread_all_clocks, .mult_enable, .pll_mult_m, .pll_div_n);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Model keeps only the bits that read back; load bit always reads 0
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == 8'h1a) mdl[a] = d & 8'h03;
    else if (a == 8'h1b) mdl[a] = d & 8'h7f;
    else if (a == 8'h1c || a == 8'h1d) mdl[a] = d;
  endtask

  // Status is hardware-driven, so the caller judges it
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    if (a != 8'h1f) chk(rd_val, mdl.exists(a) ? mdl[a] : 0, "read");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Pin sampled high at edge k; the one-cycle effects stand after edge k+2
  task automatic sync_pulse;
    @(posedge mclk);
    line_sync_pulse <= 1'b1;
    repeat (2) @(posedge mclk);
    line_sync_pulse <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(3000 * 40);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    line_sync_pulse = 1'b0;
    first_pll_lock_raw = 1'b0;
    second_pll_lock_raw = 1'b0;
    void'($urandom(32'h0058));
    mdl[8'h1a] = 0;
    mdl[8'h1b] = 8'h02;
    mdl[8'h1c] = 0;
    mdl[8'h1d] = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk(pll_mult_m, 9'h001, "m reset");
    chk(pll_div_n, 9'h001, "n reset");
    chk(pll_enable, 1'b0, "pll off");
    for (int a = 8'h1a; a <= 8'h1d; a++) rd(a[7:0]);
    rd(8'h20);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h1b, m[7:0]);
      idle(2);
      chk(pll_enable, m != 2, "pll enable");
      chk(spread_all_clocks, m[0], "spread all");
      chk(mult_enable, !m[1], "mult enable");
      rd(8'h1b);
    end
    $display("test mode done");
    for (int i = 0; i < 8; i++) begin
      raw = 3'($urandom);
      @(posedge mclk);
      first_pll_lock_raw <= raw[0];
      second_pll_lock_raw <= raw[1];
      wr(8'h1b, 8'(i << 2) | 8'h02);
      idle(4);
      chk(max_modulation_rate, i[0], "max rate");
      chk(first_pll_lock, raw[0] | i[1], "first lock");
      chk(second_pll_lock, raw[1] | i[2], "second lock");
    end
    $display("test flags done");
    for (int k = 0; k < 6; k++) begin
      nv = (k == 0) ? 8'hff : 8'($urandom);
      dv = (k == 0) ? 8'h00 : 8'($urandom);
      wr(8'h1c, nv);
      wr(8'h1d, dv);
      idle(2);
      chk(pll_mult_m, {1'b0, nv} + 9'h001, "m");
      chk(pll_div_n, {1'b0, dv} + 9'h001, "n");
      rd(8'h1c);
      rd(8'h1d);
    end
    $display("test ratio done");
    wr(8'h1b, 8'h00);
    wr(8'h1a, 8'h01);
    #1;
    chk(modulator_load, 1'b1, "load on enable");
    chk(spreading, 1'b1, "spread start");
    chk(fifo_reset, 1'b1, "fifo at start");
    idle(1);
    chk(modulator_load, 1'b0, "load pulse ends");
    wr(8'h1b, 8'h80);
    #1;
    chk(modulator_load, 1'b1, "load bit");
    rd(8'h1b);
    wr(8'h1a, 8'h01);
    #1;
    chk(modulator_load, 1'b0, "no rising enable");
    wr(8'h1b, 8'h80);
    #1;
    chk(modulator_load, 1'b1, "load again");
    wr(8'h1a, 8'h00);
    #1;
    chk(spreading, 1'b0, "spread stop");
    $display("test load done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h1b, 8'(i << 5));
      sync_pulse();
      chk(fifo_reset, i[1], "fifo at sync");
      chk(wave_reset, i[0], "wave at sync");
    end
    $display("test line sync done");
    wr(8'h1b, 8'h00);
    wr(8'h1a, 8'h03);
    #1;
    chk(modulator_load, 1'b1, "load sync start");
    idle(3);
    chk(spreading, 1'b0, "held for sync");
    rd(8'h1f);
    chk(rd_val[1], 1'b1, "waiting flag");
    sync_pulse();
    chk(spreading, 1'b1, "spread at sync");
    chk(fifo_reset, 1'b1, "fifo at sync start");
    $display("test sync start done");
    report_and_stop();
  end
endmodule
`default_nettype wire
